/* File: rtl/nbd_defs.vh */
`ifndef NBD_DEFS_VH
`define NBD_DEFS_VH

// ---------------------------------------------
// Request kinds
// ---------------------------------------------
`define NBD_KIND_CMD 3'h0
`define NBD_KIND_ADDR 3'h1
`define NBD_KIND_DIN 3'h2
`define NBD_KIND_DOUT 3'h3
`define NBD_KIND_WAIT 3'h4

// ---------------------------------------------
// Opcodes
// ---------------------------------------------
`define NBD_OP_READ1 8'h00
`define NBD_OP_READ2 8'h30
`define NBD_OP_CACHE_RD 8'h31
`define NBD_OP_CACHE_END 8'h3F
`define NBD_OP_RDOUT1 8'h05
`define NBD_OP_RDOUT2 8'hE0
`define NBD_OP_PROG1 8'h80
`define NBD_OP_PROG1_OLD 8'h81
`define NBD_OP_PROG2 8'h10
`define NBD_OP_PLANE_P 8'h11
`define NBD_OP_CACHE_PG 8'h15
`define NBD_OP_RDIN 8'h85
`define NBD_OP_ERASE1 8'h60
`define NBD_OP_ERASE2 8'hD0
`define NBD_OP_PLANE_E 8'hD1
`define NBD_OP_RESET 8'hFF
`define NBD_OP_ID 8'h90
`define NBD_OP_PARAM 8'hEC
`define NBD_OP_UID 8'hED
`define NBD_OP_SETF 8'hEF
`define NBD_OP_GETF 8'hEE
`define NBD_OP_STATUS 8'h70
`define NBD_OP_STATUS_ENH 8'h78

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define NBD_CLK_NS 40
`define NBD_ADDR_DATA_NS 70
`define NBD_TURN_NS 60
`define NBD_WB_NS 100
`define NBD_BUSY_MAX_US 500
`define NBD_ADDR_DATA_CYC ((`NBD_ADDR_DATA_NS + `NBD_CLK_NS - 1) / `NBD_CLK_NS)
`define NBD_TURN_CYC ((`NBD_TURN_NS + `NBD_CLK_NS - 1) / `NBD_CLK_NS)
`define NBD_WB_CYC ((`NBD_WB_NS + `NBD_CLK_NS - 1) / `NBD_CLK_NS)
// 500 us of 40 ns cycles, sized for the 14-bit wait counter
`define NBD_BUSY_MAX_CYC 14'h30D4

`endif

/* File: rtl/nbd_host.v */
`timescale 1ns/1ns
`include "nbd_defs.vh"
module nbd_host #(
  parameter [13:0] BUSY_LIMIT = `NBD_BUSY_MAX_CYC
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Request side
  input wire req_valid,
  input wire [2:0] req_kind,
  input wire [7:0] req_byte,
  output reg req_ready_r,
  input wire prog_enable,
  // Read data side
  output reg rd_valid_r,
  output reg [7:0] rd_data_r,
  input wire rd_ready,
  // Event pulses
  output reg bad_cmd_r,
  output reg timeout_r,
  // Flash pins
  output reg chip_select_n_r,
  output reg command_latch_strobe_r,
  output reg address_latch_strobe_r,
  output reg write_strobe_n_r,
  output reg read_strobe_n_r,
  output reg write_protect_n_r,
  output reg [7:0] io_out_r,
  output reg io_oe_r,
  input wire [7:0] io_in,
  input wire ready_busy_n
);

  // ---------------------------------------------
  // Constants
  // ---------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SETUP = 3'h1;
  localparam [2:0] S_STRB = 3'h2;
  localparam [2:0] S_HOLD = 3'h3;
  localparam [2:0] S_BWAIT = 3'h4;
  localparam [2:0] S_POLL = 3'h5;
  // Cycle counts, cut on purpose to the gap counter's width
  localparam integer ADL_INT = `NBD_ADDR_DATA_CYC;
  localparam integer TURN_INT = `NBD_TURN_CYC;
  localparam integer WB_INT = `NBD_WB_CYC;
  localparam [3:0] ADL_CYC = ADL_INT[3:0];
  localparam [3:0] TURN_CYC = TURN_INT[3:0];
  localparam [3:0] WB_CYC = WB_INT[3:0];

  // ---------------------------------------------
  // Opcode classification
  // ---------------------------------------------
  // Defined opcode bytes of all sequences
  function op_known;
    input [7:0] op;
    begin
      case (op)
        `NBD_OP_READ1, `NBD_OP_READ2, `NBD_OP_CACHE_RD,
        `NBD_OP_CACHE_END, `NBD_OP_RDOUT1, `NBD_OP_RDOUT2,
        `NBD_OP_PROG1, `NBD_OP_PROG2, `NBD_OP_CACHE_PG,
        `NBD_OP_RDIN, `NBD_OP_ERASE1, `NBD_OP_ERASE2, `NBD_OP_RESET,
        `NBD_OP_ID, `NBD_OP_PARAM, `NBD_OP_UID,
        `NBD_OP_SETF, `NBD_OP_GETF,
        `NBD_OP_STATUS, `NBD_OP_STATUS_ENH,
        `NBD_OP_PLANE_P, `NBD_OP_PLANE_E,
        `NBD_OP_PROG1_OLD: op_known = 1'b1;
        default: op_known = 1'b0;
      endcase
    end
  endfunction

  // Opcodes that start or carry program and erase
  function op_writes;
    input [7:0] op;
    begin
      case (op)
        `NBD_OP_PROG1, `NBD_OP_PROG1_OLD, `NBD_OP_PROG2,
        `NBD_OP_PLANE_P, `NBD_OP_CACHE_PG, `NBD_OP_RDIN,
        `NBD_OP_ERASE1, `NBD_OP_ERASE2,
        `NBD_OP_PLANE_E: op_writes = 1'b1;
        default: op_writes = 1'b0;
      endcase
    end
  endfunction

  // Opcodes the device takes while busy
  function op_busy_ok;
    input [7:0] op;
    begin
      op_busy_ok = (op == `NBD_OP_RESET) || (op == `NBD_OP_STATUS) ||
                   (op == `NBD_OP_STATUS_ENH);
    end
  endfunction

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [2:0] kind_r;
  reg [7:0] byte_r;
  reg [3:0] gap_r;
  reg [3:0] gap_nxt;
  reg last_addr_r;
  reg last_read_r;
  reg [13:0] wait_r;
  reg skid_v_r;
  reg [7:0] skid_r;
  reg push;
  reg accept;
  reg drop;
  wire pop;
  wire is_read;
  wire buf_full;

  assign pop = rd_valid_r & rd_ready;
  assign buf_full = rd_valid_r & skid_v_r & ~pop;
  assign is_read = (kind_r == `NBD_KIND_DOUT);

  // ---------------------------------------------
  // Sequencer next state
  // ---------------------------------------------
  always @* begin
    state_nxt = state_r;
    gap_nxt = (gap_r != 4'h0) ? gap_r - 4'h1 : 4'h0;
    accept = 1'b0;
    drop = 1'b0;
    push = 1'b0;
    case (state_r)
      S_IDLE: begin
        // One request at a time, in arrival order, so nothing is
        // slipped between the cycles of a multi-cycle sequence
        if (req_valid && req_ready_r) begin
          accept = 1'b1;
          if (req_kind == `NBD_KIND_CMD &&
              (!op_known(req_byte) ||
               (op_writes(req_byte) && !prog_enable))) begin
            drop = 1'b1;
          end else if (req_kind == `NBD_KIND_WAIT) begin
            state_nxt = S_POLL;
          end else begin
            state_nxt = S_BWAIT;
          end
        end
      end
      S_BWAIT: begin
        // Stall while busy unless the opcode is busy-safe
        if (gap_r == 4'h0 &&
            (ready_busy_n || (kind_r == `NBD_KIND_CMD &&
                              op_busy_ok(byte_r)))) begin
          state_nxt = S_SETUP;
        end
      end
      S_SETUP: state_nxt = S_STRB;
      S_STRB: begin
        state_nxt = S_HOLD;
        push = is_read;
      end
      S_HOLD: begin
        state_nxt = S_IDLE;
        if (kind_r == `NBD_KIND_CMD) begin
          gap_nxt = WB_CYC;
        end
      end
      S_POLL: begin
        if (gap_r == 4'h0 && (ready_busy_n || wait_r == 14'h0)) begin
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    if (accept && !drop) begin
      if (req_kind == `NBD_KIND_DIN && last_addr_r && gap_r < ADL_CYC) begin
        gap_nxt = ADL_CYC;
      end else if ((req_kind == `NBD_KIND_DOUT) != last_read_r) begin
        gap_nxt = (gap_r > TURN_CYC) ? gap_r : TURN_CYC;
      end
    end
  end

  // ---------------------------------------------
  // Sequencer registers
  // ---------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      state_r <= S_IDLE;
      kind_r <= `NBD_KIND_CMD;
      byte_r <= 8'h00;
      gap_r <= 4'h0;
      last_addr_r <= 1'b0;
      last_read_r <= 1'b0;
      wait_r <= 14'h0000;
      req_ready_r <= 1'b0;
      bad_cmd_r <= 1'b0;
      timeout_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gap_r <= gap_nxt;
      req_ready_r <= (state_nxt == S_IDLE) && !buf_full && !accept;
      bad_cmd_r <= drop;
      timeout_r <= (state_r == S_POLL) && (gap_r == 4'h0) &&
                   !ready_busy_n && (wait_r == 14'h0);
      if (accept) begin
        kind_r <= req_kind;
        byte_r <= req_byte;
      end
      if (accept && !drop && req_kind != `NBD_KIND_WAIT) begin
        last_addr_r <= (req_kind == `NBD_KIND_ADDR);
        last_read_r <= (req_kind == `NBD_KIND_DOUT);
      end
      if (accept && req_kind == `NBD_KIND_WAIT) begin
        wait_r <= BUSY_LIMIT;
      end else if (state_r == S_POLL && wait_r != 14'h0) begin
        wait_r <= wait_r - 14'h0001;
      end
    end
  end

  // ---------------------------------------------
  // Pin drive
  // ---------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      chip_select_n_r <= 1'b1;
      command_latch_strobe_r <= 1'b0;
      address_latch_strobe_r <= 1'b0;
      write_strobe_n_r <= 1'b1;
      read_strobe_n_r <= 1'b1;
      write_protect_n_r <= 1'b0;
      io_out_r <= 8'h00;
      io_oe_r <= 1'b0;
    end else begin
      write_protect_n_r <= prog_enable;
      if (state_nxt == S_SETUP || state_nxt == S_STRB ||
          state_nxt == S_HOLD) begin
        chip_select_n_r <= 1'b0;
        command_latch_strobe_r <= (kind_r == `NBD_KIND_CMD);
        address_latch_strobe_r <= (kind_r == `NBD_KIND_ADDR);
        io_out_r <= byte_r;
        io_oe_r <= !is_read;
        write_strobe_n_r <= !(state_nxt == S_STRB && !is_read);
        read_strobe_n_r <= !(state_nxt == S_STRB && is_read);
      end else begin
        chip_select_n_r <= 1'b1;
        command_latch_strobe_r <= 1'b0;
        address_latch_strobe_r <= 1'b0;
        write_strobe_n_r <= 1'b1;
        read_strobe_n_r <= 1'b1;
        io_oe_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // Two-entry read buffer
  // ---------------------------------------------
  always @(posedge clk) begin
    if (!rst_b) begin
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
      skid_v_r <= 1'b0;
      skid_r <= 8'h00;
    end else if (!rd_valid_r || pop) begin
      rd_valid_r <= skid_v_r | push;
      rd_data_r <= skid_v_r ? skid_r : io_in;
      skid_v_r <= skid_v_r & push;
      if (push) begin
        skid_r <= io_in;
      end
    end else if (push) begin
      skid_v_r <= 1'b1;
      skid_r <= io_in;
    end
  end

endmodule

/* File: testbench/nbd_host_chk.sv */
`timescale 1ns/1ns
// ------------------------------------
// Pin sequence checker
// ------------------------------------
module nbd_host_chk (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Flash pins
  input wire chip_select_n_r,
  input wire command_latch_strobe_r,
  input wire address_latch_strobe_r,
  input wire write_strobe_n_r,
  input wire read_strobe_n_r,
  input wire write_protect_n_r,
  input wire [7:0] io_out_r,
  input wire io_oe_r,
  input wire ready_busy_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Strobe and busy steps
  sequence cmd_fall;
    $fell(write_strobe_n_r) && command_latch_strobe_r;
  endsequence
  sequence busy_run;
    !ready_busy_n [*5];
  endsequence
  // Cycle kinds, write protect, busy opcodes, gaps and pulse length
  cmd_pins_a: assert property (cmd_fall |->
    !address_latch_strobe_r && !chip_select_n_r && read_strobe_n_r)
    else $error("command strobe with wrong pins");
  addr_pins_a: assert property ($fell(write_strobe_n_r) &&
    address_latch_strobe_r |-> !command_latch_strobe_r && io_oe_r)
    else $error("address strobe with wrong pins");
  read_pins_a: assert property ($fell(read_strobe_n_r) |->
    !command_latch_strobe_r && !address_latch_strobe_r &&
    write_strobe_n_r && !chip_select_n_r && !io_oe_r)
    else $error("read strobe with wrong pins");
  standby_pins_a: assert property (chip_select_n_r |->
    write_strobe_n_r && read_strobe_n_r && !io_oe_r)
    else $error("strobe while deselected");
  wp_prog_a: assert property (cmd_fall ##0
    io_out_r inside {8'h80, 8'h81, 8'h85, 8'h60, 8'h10, 8'h11, 8'h15,
    8'hD0, 8'hD1} |-> write_protect_n_r)
    else $error("program opcode with write protect low");
  busy_only_a: assert property (busy_run ##0 cmd_fall |->
    io_out_r inside {8'hFF, 8'h70, 8'h78})
    else $error("opcode other than reset or status while busy");
  addr_gap_a: assert property ($rose(write_strobe_n_r) &&
    address_latch_strobe_r |=> write_strobe_n_r [*2])
    else $error("strobe too soon after address");
  pulse_len_a: assert property ($fell(write_strobe_n_r) |=>
    $rose(write_strobe_n_r))
    else $error("write pulse not one cycle");
endmodule
bind nbd_host nbd_host_chk u_chk (
  .clk(clk),
  .rst_b(rst_b),
  .chip_select_n_r(chip_select_n_r),
  .command_latch_strobe_r(command_latch_strobe_r),
  .address_latch_strobe_r(address_latch_strobe_r),
  .write_strobe_n_r(write_strobe_n_r),
  .read_strobe_n_r(read_strobe_n_r),
  .write_protect_n_r(write_protect_n_r),
  .io_out_r(io_out_r),
  .io_oe_r(io_oe_r),
  .ready_busy_n(ready_busy_n)
);

/* File: testbench/nbd_flash_model.sv */
`timescale 1ns/1ns
// ------------------------------------
// Flash device model
// ------------------------------------
module nbd_flash_model #(
  parameter integer BUSY = 16
) (
  // Clock and pace
  input wire logic clk,
  input wire logic slow,
  // Flash pins
  input wire logic chip_select_n_r,
  input wire logic command_latch_strobe_r,
  input wire logic address_latch_strobe_r,
  input wire logic write_strobe_n_r,
  input wire logic read_strobe_n_r,
  input wire logic write_protect_n_r,
  input wire logic [7:0] io_out_r,
  output logic [7:0] io_in,
  output logic ready_busy_n,
  // Faults seen
  output integer viol
);
  logic we_d = 1'b1;
  logic re_d = 1'b1;
  logic [7:0] op = 8'h00;
  logic [7:0] din = 8'h00;
  logic [7:0] last = 8'h00;
  integer cnt = 0;
  integer idx = 0;
  initial viol = 0;
  // Busy low while an operation runs; bus toggles when not read
  assign ready_busy_n = (cnt == 0);
  assign io_in = (!chip_select_n_r && !read_strobe_n_r) ?
    ((op == 8'h70) ? {1'b0, ready_busy_n, 6'h00} :
    din + idx[7:0]) : ~last;
  // Capture on write strobe rise
  always @(posedge clk) begin
    we_d <= write_strobe_n_r;
    re_d <= read_strobe_n_r;
    last <= io_in;
    if (cnt > 0) cnt <= cnt - 1;
    if (read_strobe_n_r && !re_d) idx <= idx + 1;
    if (!chip_select_n_r && write_strobe_n_r && !we_d) begin
      if (command_latch_strobe_r && !address_latch_strobe_r) begin
        idx <= 0;
        op <= io_out_r;
        if (cnt > 0 && !(io_out_r inside {8'hFF, 8'h70, 8'h78}))
          viol <= viol + 1;
        else case (io_out_r)
          8'h00, 8'h3F, 8'h05, 8'hE0, 8'h80, 8'h85, 8'h60, 8'h90,
          8'hEC, 8'hED, 8'hEF, 8'hEE, 8'h70, 8'h78, 8'h11, 8'h81,
          8'hD1: ;
          8'h30, 8'h31, 8'hFF: cnt <= slow ? 4 * BUSY : BUSY;
          8'h10, 8'h15, 8'hD0: begin
            if (write_protect_n_r) cnt <= BUSY;
            else viol <= viol + 1;
          end
          default: viol <= viol + 1;
        endcase
      end else if (address_latch_strobe_r) idx <= 0;
      else din <= io_out_r;
    end
  end
endmodule

/* File: testbench/nbd_host_tb_top.sv */
`timescale 1ns/1ns
// ------------------------------------
// Host bench
// ------------------------------------
module nbd_host_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic prog_enable = 1'b0;
  logic rd_ready = 1'b0;
  logic slow = 1'b0;
  logic [2:0] req_kind = 3'h0;
  logic [7:0] req_byte = 8'h00;
  wire req_ready_r, rd_valid_r, bad_cmd_r, timeout_r, io_oe_r;
  wire chip_select_n_r, command_latch_strobe_r, address_latch_strobe_r;
  wire write_strobe_n_r, read_strobe_n_r, write_protect_n_r, ready_busy_n;
  wire [7:0] rd_data_r, io_out_r, io_in;
  integer viol, i, fails = 0, checks_done = 0, nbad = 0, nto = 0;
  logic [7:0] ops [0:24] = '{8'h00, 8'h30, 8'h31, 8'h3F, 8'h05, 8'hE0,
    8'h80, 8'h11, 8'h81, 8'h15, 8'h80, 8'h10, 8'h85, 8'h60, 8'hD1, 8'h60,
    8'hD0, 8'h90, 8'hEC, 8'hED, 8'hEF, 8'hEE, 8'h70, 8'h78, 8'hFF};
  always #20 clk = ~clk;
  nbd_host #(
    .BUSY_LIMIT(14'h14)
  ) DUT (
    .clk(clk),
    .rst_b(rst_b),
    .req_valid(req_valid),
    .req_kind(req_kind),
    .req_byte(req_byte),
    .req_ready_r(req_ready_r),
    .prog_enable(prog_enable),
    .rd_valid_r(rd_valid_r),
    .rd_data_r(rd_data_r),
    .rd_ready(rd_ready),
    .bad_cmd_r(bad_cmd_r),
    .timeout_r(timeout_r),
    .chip_select_n_r(chip_select_n_r),
    .command_latch_strobe_r(command_latch_strobe_r),
    .address_latch_strobe_r(address_latch_strobe_r),
    .write_strobe_n_r(write_strobe_n_r),
    .read_strobe_n_r(read_strobe_n_r),
    .write_protect_n_r(write_protect_n_r),
    .io_out_r(io_out_r),
    .io_oe_r(io_oe_r),
    .io_in(io_in),
    .ready_busy_n(ready_busy_n)
  );
  nbd_flash_model #(
    .BUSY(16)
  ) u_flash (
    .clk(clk),
    .slow(slow),
    .chip_select_n_r(chip_select_n_r),
    .command_latch_strobe_r(command_latch_strobe_r),
    .address_latch_strobe_r(address_latch_strobe_r),
    .write_strobe_n_r(write_strobe_n_r),
    .read_strobe_n_r(read_strobe_n_r),
    .write_protect_n_r(write_protect_n_r),
    .io_out_r(io_out_r),
    .io_in(io_in),
    .ready_busy_n(ready_busy_n),
    .viol(viol)
  );
  // Event pulse counts
  always @(posedge clk) begin
    if (bad_cmd_r === 1'b1) nbad = nbad + 1;
    if (timeout_r === 1'b1) nto = nto + 1;
  end
  task chk(input logic ok, input string msg);
    checks_done = checks_done + 1;
    if (ok !== 1'b1) begin
      fails = fails + 1;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task end_sim;
    $display("checks %0d, fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task idle;
    for (int n = 0; n < 3000 && req_ready_r !== 1'b1; n++) @(posedge clk);
    if (req_ready_r !== 1'b1) chk(1'b0, "request never taken");
  endtask
  task send(input logic [2:0] k, input logic [7:0] b);
    req_kind <= k;
    req_byte <= b;
    req_valid <= 1'b1;
    @(posedge clk);
    idle;
    req_valid <= 1'b0;
    @(posedge clk);
  endtask
  task get(input logic [7:0] e);
    rd_ready <= 1'b1;
    @(posedge clk);
    for (int n = 0; n < 3000 && rd_valid_r !== 1'b1; n++) @(posedge clk);
    chk(rd_valid_r === 1'b1 && rd_data_r === e, "read byte wrong");
    rd_ready <= 1'b0;
    @(posedge clk);
  endtask
  task t_reset;
    repeat (6) @(posedge clk);
    chk(chip_select_n_r === 1'b1 && io_oe_r === 1'b0, "pins busy");
    chk(write_protect_n_r === 1'b0, "write protect high");
    rst_b <= 1'b1;
    prog_enable <= 1'b1;
    @(posedge clk);
  endtask
  task t_prog_read;
    send(3'h0, 8'h80);
    send(3'h1, 8'h00);
    send(3'h2, 8'h5A);
    send(3'h0, 8'h10);
    send(3'h4, 8'h00);
    send(3'h0, 8'h00);
    send(3'h1, 8'h00);
    send(3'h0, 8'h30);
    send(3'h0, 8'h70);
    send(3'h3, 8'h00);
    get(8'h40);
    send(3'h0, 8'h00);
    send(3'h3, 8'h00);
    send(3'h3, 8'h00);
    repeat (8) @(posedge clk);
    chk(req_ready_r === 1'b0, "request taken with buffer full");
    get(8'h5A);
    get(8'h5B);
  endtask
  task t_ops;
    for (i = 0; i < 25; i++) send(3'h0, ops[i]);
    send(3'h4, 8'h00);
    idle;
    chk(nbad === 0 && nto === 0, "defined opcode refused");
  endtask
  task t_refuse;
    send(3'h0, 8'h01);
    repeat (2) @(posedge clk);
    chk(nbad === 1, "unknown opcode not refused");
    prog_enable <= 1'b0;
    repeat (2) @(posedge clk);
    send(3'h0, 8'h80);
    repeat (2) @(posedge clk);
    chk(nbad === 2, "program opcode sent while protected");
    send(3'h0, 8'h70);
    repeat (2) @(posedge clk);
    chk(nbad === 2, "read opcode refused while protected");
    prog_enable <= 1'b1;
  endtask
  task t_timeout;
    slow <= 1'b1;
    send(3'h0, 8'hFF);
    repeat (3) send(3'h4, 8'h00);
    idle;
    chk(nto === 2, "busy wait expiry count wrong");
    slow <= 1'b0;
    chk(viol === 0, "device saw a protocol fault");
  endtask
  // Main sequence and watchdog
  initial begin
    t_reset;
    t_prog_read;
    t_ops;
    t_refuse;
    t_timeout;
    end_sim;
  end
  initial begin
    #400000;
    fails = fails + 1;
    end_sim;
  end
endmodule
